// [design/lmrs_bank.sv]
// mode register bank: command-side write and read, decode of settings
`timescale 1ns/1ps
module lmrs_bank (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_i,
    // mode register commands, already decoded, same clock
    input wire logic mrw_i,
    input wire logic mrr_i,
    input wire logic [7:0] ma_i,
    input wire logic [7:0] op_i,
    // device state inputs
    input wire logic init_busy_i,
    input wire logic [2:0] refresh_rate_i,
    input wire logic refresh_rate_vld_i,
    // read answer
    output logic rd_valid_o,
    output logic [7:0] rd_data_o,
    output logic rd_strobe_o,
    // decoded configuration and calibration pulse
    output lmrs_pkg::lmrs_cfg_s cfg_o,
    output lmrs_pkg::lmrs_cal_e cal_cmd_o,
    output logic cal_start_o
);
    // stored writable registers, then status flops and read and decode nets
    logic [7:0] burst_r;
    logic [7:0] lat_r;
    logic [7:0] drive_r;
    logic [7:0] term_r;
    logic [7:0] mask_r;
    logic [2:0] rate_r;
    logic tuf_r;
    logic init_busy_r;
    logic [7:0] rd_nxt;
    logic rd_known;
    lmrs_pkg::lmrs_cfg_s cfg_nxt;
    // identity codes; the values are arbitrary and neutral
    localparam logic [7:0] MAKER_CODE = 8'h5A;
    localparam logic [7:0] REV_CODE = 8'h01;

    // calibration code decode, used by write path and assertion
    function automatic lmrs_pkg::lmrs_cal_e cal_decode(input logic [7:0] code);
        unique case (code)
            lmrs_pkg::LMRS_CAL_INIT: cal_decode = lmrs_pkg::LMRS_CAL_DO_INIT;
            lmrs_pkg::LMRS_CAL_LONG: cal_decode = lmrs_pkg::LMRS_CAL_DO_LONG;
            lmrs_pkg::LMRS_CAL_SHORT: cal_decode = lmrs_pkg::LMRS_CAL_DO_SHORT;
            lmrs_pkg::LMRS_CAL_RESET: cal_decode = lmrs_pkg::LMRS_CAL_DO_RESET;
            default: cal_decode = lmrs_pkg::LMRS_CAL_NONE;
        endcase
    endfunction

    // init busy is a level from the device sequencer, same clock
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            init_busy_r <= 1'b1;
        end else begin
            init_busy_r <= init_busy_i;
        end
    end

    // writes; only writable addresses accept, read-only ones ignore
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            burst_r <= lmrs_pkg::LMRS_RST_BURST;
            lat_r <= lmrs_pkg::LMRS_RST_LAT;
            drive_r <= lmrs_pkg::LMRS_RST_DRIVE;
            term_r <= lmrs_pkg::LMRS_RST_TERM;
            mask_r <= lmrs_pkg::LMRS_RST_MASK;
        end else if (mrw_i) begin
            unique case (ma_i)
                // reserved positions forced to zero on store
                lmrs_pkg::LMRS_ADDR_BURST: begin
                    // only eight-beat burst code is taken, rest kept
                    if ((op_i[2:0] & lmrs_pkg::LMRS_WMASK_BURST[2:0]) ==
                        lmrs_pkg::LMRS_BURST_8) begin
                        burst_r <= op_i & lmrs_pkg::LMRS_WMASK_BURST;
                    end
                end
                lmrs_pkg::LMRS_ADDR_LAT: lat_r <= op_i & lmrs_pkg::LMRS_WMASK_LAT;
                lmrs_pkg::LMRS_ADDR_DRIVE: drive_r <= op_i & lmrs_pkg::LMRS_WMASK_DRIVE;
                lmrs_pkg::LMRS_ADDR_TERM: term_r <= op_i & lmrs_pkg::LMRS_WMASK_TERM;
                lmrs_pkg::LMRS_ADDR_MASK: mask_r <= op_i;
                // read-only and reserved addresses change nothing
                default: burst_r <= burst_r;
            endcase
        end
    end

    // refresh status and update flag; a change beats the read clear
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            rate_r <= 3'h0;
            tuf_r <= 1'b0;
        end else begin
            if (refresh_rate_vld_i) begin
                rate_r <= refresh_rate_i;
            end
            if (refresh_rate_vld_i && refresh_rate_i != rate_r) begin
                tuf_r <= 1'b1;
            end else if (mrr_i && ma_i == lmrs_pkg::LMRS_ADDR_TEMP) begin
                tuf_r <= 1'b0;
            end
        end
    end

    // read data mux; write-only and reserved give undefined data
    always_comb begin
        rd_known = 1'b1;
        unique case (ma_i)
            lmrs_pkg::LMRS_ADDR_INFO:
                rd_nxt = lmrs_pkg::LMRS_INFO_OPTS | {7'h00, init_busy_r};
            lmrs_pkg::LMRS_ADDR_TEMP: rd_nxt = {tuf_r, 4'h0, rate_r};
            // identity codes are arbitrary neutral values
            lmrs_pkg::LMRS_ADDR_MAKER: rd_nxt = MAKER_CODE;
            lmrs_pkg::LMRS_ADDR_REV1: rd_nxt = REV_CODE;
            lmrs_pkg::LMRS_ADDR_REV2: rd_nxt = REV_CODE;
            lmrs_pkg::LMRS_ADDR_CFG: rd_nxt = lmrs_pkg::LMRS_CFG_VALUE;
            lmrs_pkg::LMRS_ADDR_DIE: rd_nxt = lmrs_pkg::LMRS_DIE_VALUE;
            default: begin
                rd_nxt = lmrs_pkg::LMRS_UNDEF_DATA;
                rd_known = 1'b0;
            end
        endcase
    end

    // read answer, one cycle after the command, strobe pulses with valid on every read
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            rd_valid_o <= 1'b0;
            rd_data_o <= 8'h00;
            rd_strobe_o <= 1'b0;
        end else begin
            rd_valid_o <= mrr_i;
            rd_strobe_o <= mrr_i;
            rd_data_o <= mrr_i ? rd_nxt : 8'h00;
        end
    end

    // calibration launch; reserved codes never start one
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            cal_cmd_o <= lmrs_pkg::LMRS_CAL_NONE;
            cal_start_o <= 1'b0;
        end else if (mrw_i && ma_i == lmrs_pkg::LMRS_ADDR_CAL) begin
            cal_cmd_o <= cal_decode(op_i);
            cal_start_o <= cal_decode(op_i) != lmrs_pkg::LMRS_CAL_NONE;
        end else begin
            cal_start_o <= 1'b0;
        end
    end

    // decode of latencies, recovery and drive; reserved codes flag invalid
    always_comb begin
        cfg_nxt = '0;
        cfg_nxt.cfg_valid = 1'b1;
        // read latency common, write latency per set
        unique case (lat_r[3:0])
            4'h1: begin cfg_nxt.read_latency = 5'd3; cfg_nxt.write_latency = 4'd1; end
            4'h4: begin cfg_nxt.read_latency = 5'd6; cfg_nxt.write_latency = 4'd3; end
            4'h6: begin cfg_nxt.read_latency = 5'd8; cfg_nxt.write_latency = 4'd4; end
            4'h7: begin cfg_nxt.read_latency = 5'd9; cfg_nxt.write_latency = 4'd5; end
            4'h8: begin
                cfg_nxt.read_latency = 5'd10;
                cfg_nxt.write_latency = lat_r[6] ? 4'd8 : 4'd6;
            end
            4'h9: begin
                cfg_nxt.read_latency = 5'd11;
                cfg_nxt.write_latency = lat_r[6] ? 4'd9 : 4'd6;
            end
            4'hA: begin
                cfg_nxt.read_latency = 5'd12;
                cfg_nxt.write_latency = lat_r[6] ? 4'd9 : 4'd6;
            end
            4'hC: begin
                cfg_nxt.read_latency = 5'd14;
                cfg_nxt.write_latency = lat_r[6] ? 4'd11 : 4'd8;
            end
            4'hE: begin
                cfg_nxt.read_latency = 5'd16;
                cfg_nxt.write_latency = lat_r[6] ? 4'd13 : 4'd8;
            end
            default: cfg_nxt.cfg_valid = 1'b0;
        endcase
        // recovery code meaning depends on the range bit
        if (!lat_r[4]) begin
            unique case (burst_r[7:5])
                3'h1: cfg_nxt.write_recovery_cycles = 5'd3;
                3'h4: cfg_nxt.write_recovery_cycles = 5'd6;
                3'h6: cfg_nxt.write_recovery_cycles = 5'd8;
                3'h7: cfg_nxt.write_recovery_cycles = 5'd9;
                default: cfg_nxt.cfg_valid = 1'b0;
            endcase
        end else begin
            unique case (burst_r[7:5])
                3'h0: cfg_nxt.write_recovery_cycles = 5'd10;
                3'h1: cfg_nxt.write_recovery_cycles = 5'd11;
                3'h2: cfg_nxt.write_recovery_cycles = 5'd12;
                3'h6: cfg_nxt.write_recovery_cycles = 5'd16;
                default: cfg_nxt.cfg_valid = 1'b0;
            endcase
        end
        // drive strength: symmetric and asymmetric codes
        unique case (drive_r[3:0])
            4'h1, 4'h2, 4'h3, 4'h9, 4'hA, 4'hB: cfg_nxt.drive_strength = drive_r[3:0];
            default: cfg_nxt.cfg_valid = 1'b0;
        endcase
        cfg_nxt.data_termination = term_r[1:0];
        cfg_nxt.powerdown_term_ctl = term_r[2];
        cfg_nxt.partial_refresh_mask = mask_r;
    end

    // decoded config registered so the output is a flop
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            cfg_o <= '0;
        end else begin
            cfg_o <= cfg_nxt;
        end
    end

    // assertions
    sequence s_rate_change;
        refresh_rate_vld_i && refresh_rate_i != rate_r;
    endsequence
    sequence s_temp_read;
        mrr_i && ma_i == lmrs_pkg::LMRS_ADDR_TEMP;
    endsequence

    a_tuf_set_change: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        s_rate_change |=> tuf_r) else $error("update flag not set on change");
    a_tuf_clear_read: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        mrr_i && ma_i == lmrs_pkg::LMRS_ADDR_TEMP && !refresh_rate_vld_i |=> !tuf_r)
        else $error("flag not cleared");
    a_temp_read_data: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        s_temp_read |=> rd_data_o[6:3] == 4'h0 && rd_data_o[7] == $past(tuf_r))
        else $error("temperature read wrong");
    a_rd_strobe_pair: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        mrr_i |=> rd_strobe_o && rd_valid_o) else $error("read strobe missing");
    a_cal_reserved_none: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        mrw_i && ma_i == lmrs_pkg::LMRS_ADDR_CAL && cal_decode(op_i) == lmrs_pkg::LMRS_CAL_NONE
        |=> !cal_start_o) else $error("reserved code started calibration");
    a_cal_valid_start: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        mrw_i && ma_i == lmrs_pkg::LMRS_ADDR_CAL && op_i == lmrs_pkg::LMRS_CAL_LONG
        |=> cal_start_o ##1 !cal_start_o) else $error("long calibration not pulsed");
    a_ro_write_keep: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        mrw_i && ma_i == lmrs_pkg::LMRS_ADDR_CFG |=> $stable(lat_r) && $stable(drive_r))
        else $error("read-only write changed state");
    a_info_busy_bit: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        mrr_i && ma_i == lmrs_pkg::LMRS_ADDR_INFO |=> rd_data_o[0] == $past(init_busy_r)
        && rd_data_o[7:6] == 2'h3) else $error("info register wrong");
    a_wl_set_b: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        lat_r[6] && lat_r[3:0] == 4'hE |=> cfg_o.write_latency == 4'd13)
        else $error("set B write latency wrong");
    a_cfg_read_value: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        mrr_i && ma_i == lmrs_pkg::LMRS_ADDR_CFG |=> rd_data_o == 8'h4F)
        else $error("configuration read wrong");

    // write command steps, one per writable register
    sequence s_burst_write;
        mrw_i && ma_i == lmrs_pkg::LMRS_ADDR_BURST;
    endsequence

    sequence s_lat_write;
        mrw_i && ma_i == lmrs_pkg::LMRS_ADDR_LAT;
    endsequence

    sequence s_drive_write;
        mrw_i && ma_i == lmrs_pkg::LMRS_ADDR_DRIVE;
    endsequence

    sequence s_term_write;
        mrw_i && ma_i == lmrs_pkg::LMRS_ADDR_TERM;
    endsequence

    sequence s_mask_write;
        mrw_i && ma_i == lmrs_pkg::LMRS_ADDR_MASK;
    endsequence

    // read of an address with no defined contents
    sequence s_undef_read;
        mrr_i && !rd_known;
    endsequence

    // stored values: reserved positions must come back as zero
    a_lat_store: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        s_lat_write |=> lat_r == ($past(op_i) & lmrs_pkg::LMRS_WMASK_LAT))
        else $error("latency store wrong");

    a_drive_store: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        s_drive_write |=> drive_r == ($past(op_i) & lmrs_pkg::LMRS_WMASK_DRIVE))
        else $error("drive store wrong");

    a_term_store: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        s_term_write |=> term_r == ($past(op_i) & lmrs_pkg::LMRS_WMASK_TERM))
        else $error("termination store wrong");

    a_mask_store: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        s_mask_write |=> mask_r == $past(op_i))
        else $error("bank mask store wrong");

    // the mask reaches the decoded output two cycles after the write
    a_mask_output: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        s_mask_write |-> ##2 cfg_o.partial_refresh_mask == $past(op_i, 2))
        else $error("bank mask output wrong");

    // a burst write with a non-eight code is refused as a whole
    a_burst_refuse: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        mrw_i && ma_i == lmrs_pkg::LMRS_ADDR_BURST && op_i[2:0] != lmrs_pkg::LMRS_BURST_8
        |=> $stable(burst_r)) else $error("bad burst code stored");

    a_burst_store: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        s_burst_write ##0 op_i[2:0] == lmrs_pkg::LMRS_BURST_8
        |=> burst_r == ($past(op_i) & lmrs_pkg::LMRS_WMASK_BURST))
        else $error("burst store wrong");

    // undefined reads still answer with strobe and fixed filler
    a_undef_strobe: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        s_undef_read |=> rd_strobe_o && rd_data_o == lmrs_pkg::LMRS_UNDEF_DATA)
        else $error("undefined read wrong");

    // no command, no answer; the data lines rest at zero
    a_rd_idle_zero: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        !mrr_i |=> !rd_valid_o && !rd_strobe_o && rd_data_o == 8'h00)
        else $error("answer without command");

    // the flag only moves on a change or a temperature read
    a_tuf_hold: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        !(refresh_rate_vld_i && refresh_rate_i != rate_r)
        && !(mrr_i && ma_i == lmrs_pkg::LMRS_ADDR_TEMP) |=> tuf_r == $past(tuf_r))
        else $error("update flag moved alone");

    a_rate_load: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        refresh_rate_vld_i |=> rate_r == $past(refresh_rate_i))
        else $error("refresh rate not loaded");

    // table end points of latency set A and both recovery ranges
    a_wl_set_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        !lat_r[6] && lat_r[3:0] == 4'hE
        |=> cfg_o.write_latency == 4'd8 && cfg_o.read_latency == 5'd16)
        else $error("set A latency wrong");

    a_wr_low_range: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        !lat_r[4] && burst_r[7:5] == 3'h7 |=> cfg_o.write_recovery_cycles == 5'd9)
        else $error("low range recovery wrong");

    a_wr_high_range: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        lat_r[4] && burst_r[7:5] == 3'h6 |=> cfg_o.write_recovery_cycles == 5'd16)
        else $error("high range recovery wrong");

    // calibration reset code launches its own action
    a_cal_reset_start: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        mrw_i && ma_i == lmrs_pkg::LMRS_ADDR_CAL && op_i == lmrs_pkg::LMRS_CAL_RESET
        |=> cal_start_o && cal_cmd_o == lmrs_pkg::LMRS_CAL_DO_RESET)
        else $error("calibration reset not launched");

    // a reserved code leaves no action behind on the kind output
    a_cal_kind_none: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        mrw_i && ma_i == lmrs_pkg::LMRS_ADDR_CAL && cal_decode(op_i) == lmrs_pkg::LMRS_CAL_NONE
        |=> cal_cmd_o == lmrs_pkg::LMRS_CAL_NONE)
        else $error("reserved code left an action");

    // die status is fixed contents
    a_die_read: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        mrr_i && ma_i == lmrs_pkg::LMRS_ADDR_DIE |=> rd_data_o == lmrs_pkg::LMRS_DIE_VALUE)
        else $error("die status read wrong");
endmodule

// [design/lmrs_pkg.sv]
// constants and carriers for the mode register bank
package lmrs_pkg;
    // register addresses on the command bus
    localparam logic [7:0] LMRS_ADDR_INFO = 8'h00;
    localparam logic [7:0] LMRS_ADDR_BURST = 8'h01;
    localparam logic [7:0] LMRS_ADDR_LAT = 8'h02;
    localparam logic [7:0] LMRS_ADDR_DRIVE = 8'h03;
    localparam logic [7:0] LMRS_ADDR_TEMP = 8'h04;
    localparam logic [7:0] LMRS_ADDR_MAKER = 8'h05;
    localparam logic [7:0] LMRS_ADDR_REV1 = 8'h06;
    localparam logic [7:0] LMRS_ADDR_REV2 = 8'h07;
    localparam logic [7:0] LMRS_ADDR_CFG = 8'h08;
    localparam logic [7:0] LMRS_ADDR_DIE = 8'h09;
    localparam logic [7:0] LMRS_ADDR_CAL = 8'h0A;
    localparam logic [7:0] LMRS_ADDR_TERM = 8'h0B;
    localparam logic [7:0] LMRS_ADDR_MASK = 8'h10;
    // reset values of writable fields
    localparam logic [7:0] LMRS_RST_BURST = 8'h03;
    localparam logic [7:0] LMRS_RST_LAT = 8'h18;
    localparam logic [7:0] LMRS_RST_DRIVE = 8'h02;
    localparam logic [7:0] LMRS_RST_TERM = 8'h00;
    localparam logic [7:0] LMRS_RST_MASK = 8'h00;
    // writable bit masks; zero positions are reserved
    localparam logic [7:0] LMRS_WMASK_BURST = 8'hE7;
    localparam logic [7:0] LMRS_WMASK_LAT = 8'hDF;
    localparam logic [7:0] LMRS_WMASK_DRIVE = 8'h0F;
    localparam logic [7:0] LMRS_WMASK_TERM = 8'h07;
    // fixed read-only contents and the eight-beat burst code
    localparam logic [7:0] LMRS_INFO_OPTS = 8'hC0;
    localparam logic [7:0] LMRS_CFG_VALUE = 8'h4F;
    localparam logic [7:0] LMRS_DIE_VALUE = 8'h20;
    localparam logic [2:0] LMRS_BURST_8 = 3'h3;
    // calibration command codes
    localparam logic [7:0] LMRS_CAL_INIT = 8'hFF;
    localparam logic [7:0] LMRS_CAL_LONG = 8'hAB;
    localparam logic [7:0] LMRS_CAL_SHORT = 8'h56;
    localparam logic [7:0] LMRS_CAL_RESET = 8'hC3;
    // undefined data returned for reserved or write-only reads
    localparam logic [7:0] LMRS_UNDEF_DATA = 8'h00;
    // decoded calibration action
    typedef enum {LMRS_CAL_NONE, LMRS_CAL_DO_INIT, LMRS_CAL_DO_LONG,
        LMRS_CAL_DO_SHORT, LMRS_CAL_DO_RESET} lmrs_cal_e;
    // decoded operating configuration
    typedef struct packed {
        logic [4:0] read_latency;
        logic [3:0] write_latency;
        logic [4:0] write_recovery_cycles;
        logic [3:0] drive_strength;
        logic [1:0] data_termination;
        logic powerdown_term_ctl;
        logic [7:0] partial_refresh_mask;
        logic cfg_valid;
    } lmrs_cfg_s;
endpackage

// [bench/lmrs_host_model.sv]
// host controller model issuing mode register commands to the bank
`timescale 1ns/1ps
module lmrs_host_model (
    // clock
    input wire logic sys_clk_i,
    // command side toward the bank
    output logic mrw_o,
    output logic mrr_o,
    output logic [7:0] ma_o,
    output logic [7:0] op_o,
    // read answer from the bank
    input wire logic rd_valid_i,
    input wire logic [7:0] rd_data_i,
    input wire logic rd_strobe_i
);
    logic derate_r; // last status asked for derated core timings
    initial begin
        mrw_o = 1'b0;
        mrr_o = 1'b0;
        ma_o = 8'h00;
        op_o = 8'h00;
        derate_r = 1'b0;
    end
    // one write command; callers keep reserved positions zero
    task automatic mr_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        mrw_o <= 1'b1;
        ma_o <= a;
        op_o <= d;
        @(posedge sys_clk_i);
        mrw_o <= 1'b0;
        // a released bus shows inverted lines, never a stale copy
        ma_o <= ~a;
        op_o <= ~d;
    endtask
    // one read command; answer sampled 1 ns after the edge that takes it
    task automatic mr_read(input logic [7:0] a, output logic [7:0] d, output logic v,
        output logic s);
        @(posedge sys_clk_i);
        mrr_o <= 1'b1;
        ma_o <= a;
        @(posedge sys_clk_i);
        mrr_o <= 1'b0;
        ma_o <= ~a;
        // answer stands for the cycle after the command edge
        #1;
        d = rd_data_i;
        v = rd_valid_i;
        s = rd_strobe_i;
        // status code 6 asks the controller to stretch core timings
        if (a == 8'h04) begin
            derate_r = (rd_data_i[2:0] == 3'h6);
        end
    endtask
endmodule

// [bench/tb_top.sv]
// self-checking bench for the mode register bank
`timescale 1ns/1ps
module tb_top;
    logic sys_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic mrw, mrr, busy = 1'b1, vld = 1'b0, rdv, rds, go;
    logic [7:0] ma, op, rdd;
    logic [7:0] d8;
    logic v1, s1;
    logic [2:0] rate = 3'h0;
    lmrs_pkg::lmrs_cfg_s cfg, e;
    lmrs_pkg::lmrs_cal_e calk;
    int bad_count = 0;
    int num_checks = 0;
    logic [3:0] codes [9] = '{4'h1, 4'h4, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hC, 4'hE};
    int rl [9] = '{3, 6, 8, 9, 10, 11, 12, 14, 16};
    int wla [9] = '{1, 3, 4, 5, 6, 6, 6, 8, 8};
    int wlb [9] = '{1, 3, 4, 5, 8, 9, 9, 11, 13};
    lmrs_bank i_lmrs_bank (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .mrw_i(mrw), .mrr_i(mrr),
        .ma_i(ma), .op_i(op), .init_busy_i(busy), .refresh_rate_i(rate),
        .refresh_rate_vld_i(vld), .rd_valid_o(rdv), .rd_data_o(rdd), .rd_strobe_o(rds),
        .cfg_o(cfg), .cal_cmd_o(calk), .cal_start_o(go));
    lmrs_host_model i_lmrs_host_model (.sys_clk_i(sys_clk_i), .mrw_o(mrw), .mrr_o(mrr),
        .ma_o(ma), .op_o(op), .rd_valid_i(rdv), .rd_data_i(rdd), .rd_strobe_i(rds));
    // 25 ns clock
    initial begin
        forever #12.5 sys_clk_i = ~sys_clk_i;
    end
    // single comparison point
    task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %0h seen %0h", n, exp, seen);
        end
    endtask
    // read and compare valid, strobe and data together
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string n);
        logic [7:0] d;
        logic v, s;
        i_lmrs_host_model.mr_read(a, d, v, s);
        check(n, {22'h0, v, s, d}, {24'h3, exp});
    endtask
    // write, let the decode settle two edges, compare whole configuration
    task automatic wcfg(input logic [7:0] a, input logic [7:0] d, input string n);
        i_lmrs_host_model.mr_write(a, d);
        repeat (2) @(posedge sys_clk_i);
        #1;
        check(n, 32'(cfg), 32'(e));
    endtask
    task automatic load_rate(input logic [2:0] r);
        @(posedge sys_clk_i);
        rate <= r;
        vld <= 1'b1;
        @(posedge sys_clk_i);
        vld <= 1'b0;
    endtask
    task automatic cal(input logic [7:0] c, input lmrs_pkg::lmrs_cal_e k, input logic g);
        i_lmrs_host_model.mr_write(8'h0A, c);
        #1;
        check("cal start", 32'(go), 32'(g));
        check("cal kind", 32'(calk), 32'(k));
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // watchdog cuts a hang short
    initial begin
        repeat (20000) @(posedge sys_clk_i);
        bad_count++;
        print_verdict();
    end
    initial begin
        e = '{5'h0A, 4'h6, 5'h0A, 4'h2, 2'h0, 1'b0, 8'h00, 1'b1};
        repeat (6) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        // defaults after reset, flag clear
        repeat (2) @(posedge sys_clk_i);
        #1;
        check("defaults", 32'(cfg), 32'(e));
        rd(8'h04, 8'h00, "temp at start");
        rd(8'h00, 8'hC1, "info busy");
        busy <= 1'b0;
        rd(8'h00, 8'hC0, "info done");
        $display("test reset and info done");
        // read-only writes change nothing; undefined reads still strobe
        i_lmrs_host_model.mr_write(8'h08, 8'h00);
        i_lmrs_host_model.mr_write(8'h04, 8'h87);
        wcfg(8'h00, 8'h01, "ro write cfg");
        rd(8'h08, 8'h4F, "config");
        rd(8'h04, 8'h00, "temp after write");
        i_lmrs_host_model.mr_read(8'h0C, d8, v1, s1);
        check("reserved read", {v1, s1}, 2'h3);
        i_lmrs_host_model.mr_read(8'h02, d8, v1, s1);
        check("wo read", {v1, s1}, 2'h3);
        $display("test read only done");
        // latency tables, both write latency sets
        for (int b = 0; b < 2; b++) begin
            for (int i = 0; i < 9; i++) begin
                e.read_latency = 5'(rl[i]);
                e.write_latency = 4'(b ? wlb[i] : wla[i]);
                wcfg(8'h02, {1'b0, 1'(b), 2'h1, codes[i]}, "latency");
            end
        end
        e.read_latency = 5'h00;
        e.write_latency = 4'h0;
        e.cfg_valid = 1'b0;
        wcfg(8'h02, 8'h12, "lat reserved");
        check("lat reserved valid", 32'(cfg.cfg_valid), 32'h0);
        e.cfg_valid = 1'b1;
        e.read_latency = 5'h0A;
        e.write_latency = 4'h6;
        wcfg(8'h02, 8'h18, "lat restore");
        $display("test latency done");
        // write recovery in both ranges; non-eight burst refused
        for (int i = 0; i < 4; i++) begin
            e.write_recovery_cycles = 5'(i == 3 ? 16 : 10 + i);
            wcfg(8'h01, {(i == 3) ? 3'h6 : 3'(i), 5'h03}, "recovery high");
        end
        wcfg(8'h01, 8'h22, "burst four");
        e.write_recovery_cycles = 5'h08;
        wcfg(8'h02, 8'h08, "range low");
        for (int i = 0; i < 4; i++) begin
            e.write_recovery_cycles = 5'(i == 0 ? 3 : (i == 1 ? 6 : 6 + i));
            wcfg(8'h01, {((i == 0) ? 3'h1 : ((i == 1) ? 3'h4 : 3'(4 + i))), 5'h03},
                "recovery low");
        end
        // code 7 is reserved in the high range, so the decode goes invalid
        e.write_recovery_cycles = 5'h00;
        e.cfg_valid = 1'b0;
        wcfg(8'h02, 8'h18, "range high");
        e.write_recovery_cycles = 5'h0A;
        e.cfg_valid = 1'b1;
        wcfg(8'h01, 8'h03, "recovery restore");
        $display("test recovery done");
        // drive strength, termination, bank mask
        for (int i = 1; i < 12; i++) begin
            if (i < 4 || i > 8) begin
                e.drive_strength = 4'(i);
                wcfg(8'h03, 8'(i), "drive");
            end
        end
        for (int t = 0; t < 8; t++) begin
            e.data_termination = 2'(t);
            e.powerdown_term_ctl = t[2];
            wcfg(8'h0B, 8'(t), "termination");
        end
        e.partial_refresh_mask = 8'hA5;
        wcfg(8'h10, 8'hA5, "bank mask");
        $display("test drive termination mask done");
        // refresh status and update flag
        load_rate(3'h3);
        rd(8'h04, 8'h83, "rate set");
        rd(8'h04, 8'h03, "flag cleared");
        load_rate(3'h3);
        rd(8'h04, 8'h03, "same rate");
        load_rate(3'h6);
        rd(8'h04, 8'h86, "derate code");
        check("derate", 32'(i_lmrs_host_model.derate_r), 32'h1);
        load_rate(3'h7);
        rd(8'h04, 8'h87, "hot code");
        $display("test temperature done");
        // calibration codes, then a reserved one
        cal(8'hFF, lmrs_pkg::LMRS_CAL_DO_INIT, 1'b1);
        cal(8'hAB, lmrs_pkg::LMRS_CAL_DO_LONG, 1'b1);
        cal(8'h56, lmrs_pkg::LMRS_CAL_DO_SHORT, 1'b1);
        cal(8'hC3, lmrs_pkg::LMRS_CAL_DO_RESET, 1'b1);
        cal(8'h12, lmrs_pkg::LMRS_CAL_NONE, 1'b0);
        $display("test calibration done");
        print_verdict();
    end
endmodule
